// >>> gauge_cfg.svh
// Purpose: Constants for the battery gauge and warning logic
// Assumes: Voltage in 10 mV units, capacity in whole percent
// Notes:   Included by the principal design file only
`ifndef GAUGE_CFG_SVH
`define GAUGE_CFG_SVH

// ----------------------------------------------------------------
// Gauge thresholds
// ----------------------------------------------------------------
`define FULL_PCT      8'h55
`define LOWCAP_PCT    8'h0A
`define RECHARGE_PCT  8'h32
`define RED_STEP_X8   11'h018
`define ORNG_BASE_X8  11'h050
`define ORNG_STEP_X8  11'h064
`define RED_ONLY_MASK 10'h007
`define LOWCAP_MASK   10'h003
`define ALL_LEDS      10'h3FF

// ----------------------------------------------------------------
// Voltage thresholds (10 mV units)
// ----------------------------------------------------------------
`define VOLT_HIGH     12'hAF0
`define VOLT_LOW      12'h91A
`define VOLT_SAVER    12'h834

// ----------------------------------------------------------------
// Timing and module map
// ----------------------------------------------------------------
`define CLK_HZ        125000000
`define FLASH_HZ      1
`define FLASH_HALF_CYC (`CLK_HZ / (2 * `FLASH_HZ))
`define REMOTE_MASK   8'h01
`define REMOTE_IDX    3'h0
`define LAST_MOD      3'h7

`endif

// >>> gauge_pkg.sv
// Purpose: Types shared by the battery gauge and warning logic
// Assumes: Numbers live in gauge_cfg.svh
// Notes:   Nothing here carries a value
`default_nettype none

package gauge_pkg;

    // Auto-restore sequencer states
    typedef enum logic [1:0] {R_LATCH, R_SCAN, R_SEND, R_DONE} restore_e;

    // Battery report from the drive power module
    typedef struct packed {
        logic        valid;
        logic [11:0] volt;
        logic [7:0]  cap;
    } gauge_s;

    // Warning flags
    typedef struct packed {
        logic high;
        logic low;
        logic lowcap;
    } warn_s;

    // Whole state of the block
    typedef struct packed {
        restore_e    rstate;
        logic [2:0]  idx;
        logic [7:0]  pend;
        logic        need_cycle;
        logic [7:0]  fault_mask;
        logic        req;
        logic        busy;
        logic        permit;
        logic        status_led;
        logic [26:0] flash_cnt;
        logic        flash_on;
        logic [11:0] volt;
        logic [7:0]  cap;
        warn_s       warn;
        logic        reduced;
        logic [9:0]  leds;
    } st_s;

endpackage

`default_nettype wire

// >>> battery_gauge_warning_logic.sv
// Purpose: Ten-LED capacity bar, battery warnings, battery saver
//          and configuration auto-restore after module swap
// Assumes: Battery report arrives as a valid-qualified word;
//          power-up equals release of rst_n_in
// Notes:   All outputs are state flops; fault cleared by reset only
`include "gauge_cfg.svh"
`default_nettype none

module battery_gauge_warning_logic #(
    parameter int unsigned FLASH_HALF_CYC = `FLASH_HALF_CYC
) (
    // Clock and reset
    input  wire logic              clk_in,
    input  wire logic              rst_n_in,
    // Battery report and joystick
    input  wire gauge_pkg::gauge_s gauge_in,
    input  wire logic              joy_neutral_in,
    // Module health seen at power-up
    input  wire logic [7:0]        swap_mask_in,
    input  wire logic [7:0]        csum_err_mask_in,
    input  wire logic              remote_new_in,
    // Restore handshake with the system bus
    input  wire logic              restore_ack_in,
    input  wire logic              restore_cycle_in,
    output logic                   restore_req_out,
    output logic [2:0]             restore_mod_out,
    output logic                   restore_busy_out,
    // Gauge, warnings and drive limits
    output logic [9:0]             led_out,
    output gauge_pkg::warn_s       warn_out,
    output logic                   reduced_drive_out,
    output logic                   drive_permit_out,
    // Fault indication
    output logic                   status_led_out,
    output logic [7:0]             fault_mask_out
);

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------

    // LED k lit when capacity reaches its threshold; led 0 always on
    function automatic logic [9:0] lit_mask(input logic [7:0] cap);
        logic [10:0] c8;
        logic [10:0] thr;
        lit_mask = '0;
        c8       = {cap, 3'h0};
        for (int k = 0; k < 10; k++)
        begin
            if (k < 3)
                thr = 11'(k) * `RED_STEP_X8;
            else
                thr = `ORNG_BASE_X8 + 11'(k - 3) * `ORNG_STEP_X8;
            lit_mask[k] = (c8 >= thr);
        end
    endfunction

    localparam logic [26:0] HALF_M1 = 27'(FLASH_HALF_CYC - 1);

    gauge_pkg::st_s s, n;
    logic [9:0]     lit;
    logic           any_warn;

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------

    // Flash timebase, battery evaluation and restore sequencer
    always_comb
    begin
        n   = s;
        lit = '0;
        any_warn = 1'b0;

        // Equal halves so on time matches off time
        if (s.flash_cnt == HALF_M1)
        begin
            n.flash_cnt = '0;
            n.flash_on  = ~s.flash_on;
        end
        else
            n.flash_cnt = s.flash_cnt + 27'h0000001;

        // Latch a new report only when the bus marks it valid
        if (gauge_in.valid)
        begin
            n.volt = gauge_in.volt;
            n.cap  = gauge_in.cap;
        end

        n.warn.high = (n.volt > `VOLT_HIGH);
        n.reduced   = (n.volt < `VOLT_SAVER);

        // Low voltage is judged only at neutral, held while driving
        if (joy_neutral_in)
            n.warn.low = (n.volt < `VOLT_LOW);

        // Low capacity needs a real recharge to clear
        if (n.cap < `LOWCAP_PCT)
            n.warn.lowcap = 1'b1;
        else if (n.cap >= `RECHARGE_PCT)
            n.warn.lowcap = 1'b0;

        lit      = lit_mask(n.cap);
        any_warn = n.warn.high | n.warn.low
                 | ((lit & ~`RED_ONLY_MASK) == 10'h000);

        // Low capacity wins: only the two leftmost reds blink
        if (n.warn.lowcap)
            n.leds = n.flash_on ? `LOWCAP_MASK : 10'h000;
        else if (any_warn)
            n.leds = n.flash_on ? lit : 10'h000;
        else
            n.leds = lit;

        // Auto-restore runs once per power-up
        unique case (s.rstate)
            gauge_pkg::R_LATCH:
            begin
                // New remote pushes to every other module
                if (remote_new_in)
                    n.pend = ~`REMOTE_MASK;
                else
                    n.pend = (swap_mask_in | csum_err_mask_in)
                           & ~`REMOTE_MASK;
                n.idx    = `REMOTE_IDX;
                n.busy   = 1'b1;
                n.rstate = gauge_pkg::R_SCAN;
            end
            gauge_pkg::R_SCAN:
            begin
                if (s.pend[s.idx])
                begin
                    n.req    = 1'b1;
                    n.rstate = gauge_pkg::R_SEND;
                end
                else if (s.idx == `LAST_MOD)
                    n.rstate = gauge_pkg::R_DONE;
                else
                    n.idx = s.idx + 3'h1;
            end
            gauge_pkg::R_SEND:
            begin
                // Request holds until the bus accepts the backup
                if (restore_ack_in)
                begin
                    n.req         = 1'b0;
                    n.pend[s.idx] = 1'b0;
                    if (restore_cycle_in)
                    begin
                        n.need_cycle        = 1'b1;
                        n.fault_mask[s.idx] = 1'b1;
                    end
                    if (s.idx == `LAST_MOD)
                        n.rstate = gauge_pkg::R_DONE;
                    else
                    begin
                        n.idx    = s.idx + 3'h1;
                        n.rstate = gauge_pkg::R_SCAN;
                    end
                end
            end
            gauge_pkg::R_DONE:
                n.busy = 1'b0;
        endcase

        // Own flop for the permit pin, so no gate sits behind it
        n.permit = ~n.busy;

        // Code one blink; only a power cycle clears it
        n.status_led = n.need_cycle ? n.flash_on : 1'b1;
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------

    // Reset doubles as power cycle, wiping the fault record
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            s            <= '0;
            s.rstate     <= gauge_pkg::R_LATCH;
            s.status_led <= 1'b1;
            s.leds       <= 10'h001;
            s.permit     <= 1'b1;
        end
        else
            s <= n;
    end

    // ----------------------------------------------------------------
    // Outputs, all straight from state flops
    // ----------------------------------------------------------------
    assign led_out           = s.leds;
    assign warn_out          = s.warn;
    assign reduced_drive_out = s.reduced;
    assign drive_permit_out  = s.permit;
    assign restore_req_out   = s.req;
    assign restore_mod_out   = s.idx;
    assign restore_busy_out  = s.busy;
    assign status_led_out    = s.status_led;
    assign fault_mask_out    = s.fault_mask;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    sequence seq_send;
        restore_req_out && !restore_ack_in;
    endsequence

    sequence seq_take;
        restore_req_out && restore_ack_in && restore_cycle_in;
    endsequence

    sequence seq_power_up;
        s.rstate == gauge_pkg::R_LATCH;
    endsequence

    chk_full_all_lit: assert property (
        (s.cap >= `FULL_PCT) && !s.warn.high && !s.warn.low && !s.warn.lowcap
        |-> led_out == `ALL_LEDS)
        else $error("full battery not showing ten LEDs");

    chk_bar_from_left: assert property (
        !s.warn.lowcap && (led_out != 10'h000)
        |-> ((10'(led_out + 10'h001)) & led_out) == 10'h000)
        else $error("gauge bar not contiguous from the left");

    chk_reserve_flash: assert property (
        (s.rstate != gauge_pkg::R_LATCH) && (lit_mask(s.cap) & ~`RED_ONLY_MASK) == 10'h000
        |-> led_out == (s.flash_on ? (s.warn.lowcap ? `LOWCAP_MASK : lit_mask(s.cap)) : 10'h000))
        else $error("reserve range not flashing lit LEDs");

    chk_saver_limit: assert property (
        gauge_in.valid |=> reduced_drive_out == ($past(gauge_in.volt) < `VOLT_SAVER))
        else $error("battery saver limit wrong");

    chk_high_raise: assert property (
        gauge_in.valid && (gauge_in.volt > `VOLT_HIGH) |=> warn_out.high)
        else $error("high warning not raised");

    chk_high_clear: assert property (
        gauge_in.valid && (gauge_in.volt < `VOLT_HIGH) |=> !warn_out.high)
        else $error("high warning did not clear");

    chk_low_raise: assert property (
        gauge_in.valid && (gauge_in.volt < `VOLT_LOW) && joy_neutral_in
        |=> warn_out.low)
        else $error("low warning not raised at neutral");

    chk_low_hold: assert property (
        warn_out.low && !joy_neutral_in |=> warn_out.low)
        else $error("low warning dropped while driving");

    chk_lowcap_two: assert property (
        warn_out.lowcap |-> (led_out & ~`LOWCAP_MASK) == 10'h000)
        else $error("low capacity shows more than two LEDs");

    chk_lowcap_sticky: assert property (
        warn_out.lowcap && !(gauge_in.valid && gauge_in.cap >= `RECHARGE_PCT)
        |=> warn_out.lowcap)
        else $error("low capacity cleared without recharge");

    chk_restore_hold: assert property (
        seq_send |=> restore_req_out && restore_mod_out != `REMOTE_IDX)
        else $error("restore request dropped or aimed at remote");

    chk_fault_code: assert property (
        seq_take |=> fault_mask_out[$past(restore_mod_out)] ##1 status_led_out == s.flash_on)
        else $error("module fault not indicated after restore");

    chk_flash_even: assert property (
        s.flash_cnt <= HALF_M1)
        else $error("flash timebase overran half period");

    // ----------------------------------------------------------------
    // Warning, gauge order, power-up and timebase checks
    // ----------------------------------------------------------------

    // Any warning but low capacity blinks the lit bar
    chk_warn_flash: assert property (
        (warn_out.high || warn_out.low) && !warn_out.lowcap
        |-> led_out == (s.flash_on ? lit_mask(s.cap) : 10'h000))
        else $error("warning not flashing the lit LEDs");

    chk_warn_drive: assert property (
        warn_out.high || warn_out.low || warn_out.lowcap
        |-> drive_permit_out == !restore_busy_out)
        else $error("warning blocked driving");

    chk_lowcap_set: assert property (
        gauge_in.valid && (gauge_in.cap < `LOWCAP_PCT) |=> warn_out.lowcap)
        else $error("low capacity warning not raised");

    chk_high_hold: assert property (
        !gauge_in.valid |=> $stable(warn_out.high))
        else $error("high warning moved without a report");

    // Orange starts at the fourth LED, reds fill first
    chk_orange_lit: assert property (
        !s.warn.high && !s.warn.low && !s.warn.lowcap && (s.cap >= `LOWCAP_PCT)
        |-> led_out[3] && (led_out[2:0] == 3'h7))
        else $error("orange segment order wrong");

    // Power-up latch cycle: masks taken, fault record empty
    chk_remote_push: assert property (
        seq_power_up ##0 remote_new_in |=> restore_busy_out && (s.pend == ~`REMOTE_MASK))
        else $error("new remote not pushing to all modules");

    chk_remote_skip: assert property (
        seq_power_up |=> !s.pend[`REMOTE_IDX])
        else $error("remote scheduled for its own restore");

    chk_fault_clear: assert property (
        seq_power_up |-> (fault_mask_out == 8'h00) && status_led_out)
        else $error("fault indication survived a power cycle");

    // Phase may only turn at the end of a half period
    chk_flash_turn: assert property (
        1'b1 |=> s.flash_on == ($past(s.flash_on) ^ ($past(s.flash_cnt) == HALF_M1)))
        else $error("flash phase turned mid half period");

endmodule

`default_nettype wire

// >>> restore_bus_model.sv
// Purpose: Far side of the restore handshake, a system-bus stand-in
// Assumes: One request at a time; ack is a one-cycle pulse
// Notes:   Answers after a settable delay; logs served modules
`default_nettype none

module restore_bus_model (
    // Clock and reset
    input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    // Request from the block
    input  wire logic       req_in,
    input  wire logic [2:0] mod_in,
    // Behaviour knobs
    input  wire logic [3:0] delay_in,
    input  wire logic [7:0] cycle_mask_in,
    // Answer to the block
    output logic            ack_out,
    output logic            cycle_out,
    output logic [7:0]      served_out
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [3:0] wait_r;

    // Ack after delay; cycle flag garbles when not qualified, so no stale value is trusted
    always @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            ack_out    <= 1'b0;
            cycle_out  <= 1'b0;
            served_out <= 8'h00;
            wait_r     <= 4'h0;
        end
        else if (ack_out)
        begin
            ack_out   <= 1'b0;
            cycle_out <= ~cycle_out;
            wait_r    <= 4'h0;
        end
        else if (req_in && wait_r >= delay_in)
        begin
            ack_out    <= 1'b1;
            cycle_out  <= cycle_mask_in[mod_in];
            served_out <= served_out | (8'h01 << mod_in);
        end
        else
        begin
            cycle_out <= ~cycle_out;
            if (req_in)
                wait_r <= wait_r + 4'h1;
        end
    end

endmodule

`default_nettype wire

// >>> tb.sv
// Purpose: Self-checking bench for the battery gauge and warning logic
// Assumes: Flash half period shortened to 8 cycles
// Notes:   Inputs change at the falling edge only
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------------------------------
    // Signals
    // ----------------------------------------------------------------
    logic              clk_in = 1'b0;
    logic              rst_n_in = 1'b0;
    gauge_pkg::gauge_s gauge_in = '0;
    logic              joy_neutral_in = 1'b1;
    logic [7:0]        swap_mask_in = 8'h00;
    logic [7:0]        csum_err_mask_in = 8'h00;
    logic              remote_new_in = 1'b0;
    logic              restore_ack_in;
    logic              restore_cycle_in;
    logic              restore_req_out;
    logic [2:0]        restore_mod_out;
    logic              restore_busy_out;
    logic [9:0]        led_out;
    gauge_pkg::warn_s  warn_out;
    logic              reduced_drive_out;
    logic              drive_permit_out;
    logic              status_led_out;
    logic [7:0]        fault_mask_out;
    logic [3:0]        delay = 4'h0;
    logic [7:0]        cycle_mask = 8'h00;
    logic [7:0]        served;
    int                err_count = 0;
    int                compares = 0;

    // Short flash period keeps the run brief
    battery_gauge_warning_logic #(.FLASH_HALF_CYC(8)) dut (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .gauge_in(gauge_in), .joy_neutral_in(joy_neutral_in),
        .swap_mask_in(swap_mask_in), .csum_err_mask_in(csum_err_mask_in), .remote_new_in(remote_new_in),
        .restore_ack_in(restore_ack_in), .restore_cycle_in(restore_cycle_in),
        .restore_req_out(restore_req_out), .restore_mod_out(restore_mod_out),
        .restore_busy_out(restore_busy_out), .led_out(led_out), .warn_out(warn_out),
        .reduced_drive_out(reduced_drive_out), .drive_permit_out(drive_permit_out),
        .status_led_out(status_led_out), .fault_mask_out(fault_mask_out));

    restore_bus_model bus (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .req_in(restore_req_out), .mod_in(restore_mod_out),
        .delay_in(delay), .cycle_mask_in(cycle_mask), .ack_out(restore_ack_in),
        .cycle_out(restore_cycle_in), .served_out(served));

    // 125 MHz clock
    always #4 clk_in = ~clk_in;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task automatic chk(input string name, input logic [9:0] exp, input logic [9:0] got);
        compares++;
        if (got !== exp)
        begin
            err_count++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Power cycle; masks are held so the first edge after release sees them
    task automatic power_up(input logic [7:0] swp, input logic [7:0] csm, input logic nw);
        @(negedge clk_in);
        rst_n_in = 1'b0;
        swap_mask_in = swp;
        csum_err_mask_in = csm;
        remote_new_in = nw;
        gauge_in.valid = 1'b0;
        repeat (12) @(negedge clk_in);
        chk("led_rst", 10'h001, led_out);
        rst_n_in = 1'b1;
        @(negedge clk_in);
        chk("busy", 10'h001, restore_busy_out);
        chk("permit_busy", 10'h000, drive_permit_out);
    endtask

    // Waits for the scan to finish under a bound
    task automatic wait_idle();
        int n;
        n = 0;
        while (restore_busy_out !== 1'b0 && n < 300)
        begin
            @(negedge clk_in);
            n++;
        end
        chk("busy_done", 10'h000, restore_busy_out);
        chk("permit", 10'h001, drive_permit_out);
    endtask

    // One battery report, then outputs settle
    task automatic report(input logic [11:0] v, input logic [7:0] c);
        @(negedge clk_in);
        gauge_in = '{valid: 1'b1, volt: v, cap: c};
        @(negedge clk_in);
        gauge_in.valid = 1'b0;
        repeat (2) @(negedge clk_in);
    endtask

    // Counts lit and dark cycles over two flash periods
    task automatic flash(input string name, input logic sel, input logic [9:0] pat, input int exp_on);
        logic [9:0] s;
        int         on;
        int         off;
        on = 0;
        off = 0;
        repeat (32)
        begin
            @(negedge clk_in);
            s = sel ? {9'h000, status_led_out} : led_out;
            if (s === pat)
                on++;
            else if (s === 10'h000)
                off++;
        end
        chk(name, 10'(exp_on), 10'(on));
        chk(name, 10'(32 - exp_on), 10'(off));
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_restore_swap();
        delay = 4'h0;
        cycle_mask = 8'h04;
        power_up(8'h84, 8'h09, 1'b0);
        wait_idle();
        chk("served", 10'h08C, served);
        chk("fault", 10'h004, fault_mask_out);
        chk("req_idle", 10'h000, restore_req_out);
        chk("mod_last", 10'h007, restore_mod_out);
        flash("status_blink", 1'b1, 10'h001, 16);
    endtask

    task automatic t_restore_new_remote();
        delay = 4'h5;
        cycle_mask = 8'h00;
        power_up(8'h00, 8'h00, 1'b1);
        chk("fault_clr", 10'h000, fault_mask_out);
        wait_idle();
        chk("served_all", 10'h0FE, served);
        flash("status_steady", 1'b1, 10'h001, 32);
    endtask

    task automatic t_gauge();
        report(12'h9C4, 8'h55);
        chk("led_full", 10'h3FF, led_out);
        report(12'h9C4, 8'h54);
        chk("led_84", 10'h1FF, led_out);
        report(12'h9C4, 8'h32);
        chk("led_50", 10'h07F, led_out);
        chk("no_warn", 10'h000, warn_out);
    endtask

    task automatic t_lowcap();
        report(12'h7D0, 8'h05);
        chk("lowcap", 10'h001, warn_out.lowcap);
        chk("reduced", 10'h001, reduced_drive_out);
        chk("permit_lc", 10'h001, drive_permit_out);
        flash("lowcap_led", 1'b0, 10'h003, 16);
        report(12'h9C4, 8'h28);
        chk("lowcap_hold", 10'h001, warn_out.lowcap);
        report(12'h9C4, 8'h32);
        chk("lowcap_clr", 10'h000, warn_out.lowcap);
        chk("led_steady", 10'h07F, led_out);
    endtask

    task automatic t_high();
        report(12'hAF1, 8'h55);
        chk("high", 10'h001, warn_out.high);
        chk("permit_hi", 10'h001, drive_permit_out);
        flash("high_led", 1'b0, 10'h3FF, 16);
        report(12'hAF0, 8'h55);
        chk("high_clr", 10'h000, warn_out.high);
        chk("led_hi_clr", 10'h3FF, led_out);
    endtask

    task automatic t_low();
        joy_neutral_in = 1'b0;
        report(12'h919, 8'h55);
        chk("low_moving", 10'h000, warn_out.low);
        joy_neutral_in = 1'b1;
        repeat (3) @(negedge clk_in);
        chk("low_set", 10'h001, warn_out.low);
        chk("permit_lo", 10'h001, drive_permit_out);
        joy_neutral_in = 1'b0;
        report(12'h9C4, 8'h55);
        chk("low_hold", 10'h001, warn_out.low);
        joy_neutral_in = 1'b1;
        repeat (3) @(negedge clk_in);
        chk("low_clr", 10'h000, warn_out.low);
        report(12'h833, 8'h55);
        chk("saver_on", 10'h001, reduced_drive_out);
        report(12'h834, 8'h55);
        chk("saver_off", 10'h000, reduced_drive_out);
    endtask

    // ----------------------------------------------------------------
    // Verdict and sequencing
    // ----------------------------------------------------------------
    task automatic wrap_up();
        $display("errors %0d compares %0d", err_count, compares);
        if (err_count == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Run is a few hundred cycles; the limit of 50000 cycles leaves wide margin
    initial
    begin
        #400000;
        err_count++;
        wrap_up();
    end

    // Main sequence
    initial
    begin
        t_restore_swap();
        t_gauge();
        t_lowcap();
        t_high();
        t_low();
        t_restore_new_remote();
        wrap_up();
    end

endmodule

`default_nettype wire
